// File: common/pfm_consts.vh
// constants of the protection and fault manager
`ifndef PFM_CONSTS_VH
`define PFM_CONSTS_VH

// ------------------------------------------------------------
// fault propagation configuration, field positions
// ------------------------------------------------------------
`define PFM_PROP_TEMP_MSG   7
`define PFM_PROP_PG_MSG     6
`define PFM_PROP_TRACK      5
`define PFM_PROP_OTEMP      4
`define PFM_PROP_OCUR       3
`define PFM_PROP_UVOLT      2
`define PFM_PROP_OVOLT      1
`define PFM_PROP_PHASE      0
`define PFM_PROP_RESET      8'h3f

// ------------------------------------------------------------
// protection status register, field positions (active low)
// ------------------------------------------------------------
`define PFM_ST_PG           0
`define PFM_ST_OC           1
`define PFM_ST_UV           2
`define PFM_ST_OT           3
`define PFM_ST_TR           4
`define PFM_ST_OV           5
`define PFM_ST_RESET        6'h3f

// ------------------------------------------------------------
// protection config one, field positions (1 = latching; PFM_PC1_TRACK_DIS and PFM_CLS_TCOMP_DIS: 1 = disabled)
// ------------------------------------------------------------
`define PFM_PC1_TRACK_DIS   5
`define PFM_PC1_OT_LATCH    4
`define PFM_PC1_OC_LATCH    3
`define PFM_PC1_UV_LATCH    2
`define PFM_PC1_OV_LATCH    1
`define PFM_PC1_RESET       8'h00
`define PFM_CLS_TCOMP_DIS   0
`define PFM_CLS_RESET       8'h00

// ------------------------------------------------------------
// thresholds and timing
// ------------------------------------------------------------
`define PFM_PG_HIGH_PCT     8'd110
`define PFM_PG_LOW90_PCT    8'd90
`define PFM_PG_LOW95_PCT    8'd95
`define PFM_OV_MIN_PCT      8'd110
`define PFM_OV_MAX_PCT      8'd130
`define PFM_OV_FLOOR_MV     16'd1000
`define PFM_TRACK_MV        16'd250
`define PFM_OT_FAULT_C      8'd130
`define PFM_OT_WARN_C       8'd120
`define PFM_CLK_MHZ         100
`define PFM_HICCUP_MS       130
`define PFM_HICCUP_CYC      (`PFM_HICCUP_MS * `PFM_CLK_MHZ * 1000)

`endif

// File: tb/pfm_fault_manager_asserts.sv
// port assertions of the protection and fault manager
`timescale 1ns/1ns
module pfm_fault_manager_asserts (
  input wire        i_clock,
  input wire        i_resetn,
  input wire [15:0] i_vout_mv,
  input wire [15:0] i_vset_mv,
  input wire [7:0]  i_temp_c,
  input wire        i_steady,
  input wire        i_pg_low_95,
  input wire        i_power_ok_pin_in,
  input wire [5:0]  o_protection_flag_reg,
  input wire        o_power_ok_pin_oe,
  input wire        o_power_ok_pin_out,
  input wire        o_conv_on,
  input wire        o_regular_off,
  input wire        o_hs_force_off,
  input wire        o_ls_force_on
);
  wire [31:0] v_x    = {16'h0, i_vout_mv} * 32'd100;
  wire [31:0] s_x    = {16'h0, i_vset_mv};
  wire        in_win = v_x <= s_x * 32'd110 && v_x >= s_x * (i_pg_low_95 ? 32'd95 : 32'd90);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // three samples cover the status stage and the flag register
  sequence s_hot; (i_temp_c > 8'h82) [*3]; endsequence
  sequence s_moving; (!i_steady) [*3]; endsequence
  sequence s_outside; (i_steady && !in_win) [*3]; endsequence
  sequence s_ext_low; (i_steady && !i_power_ok_pin_in) [*3]; endsequence
  AST_PG_OPEN_DRAIN: assert property (o_power_ok_pin_out == 1'b0)
    else $error("power ok pin driven high");
  AST_PG_TRANSITION: assert property (s_moving |-> o_power_ok_pin_oe)
    else $error("power ok released while not settled");
  AST_PG_OUTSIDE: assert property (s_outside |-> o_power_ok_pin_oe && !o_protection_flag_reg[0])
    else $error("power ok warning missing");
  AST_PG_EXTERNAL: assert property (s_ext_low |-> !o_protection_flag_reg[0])
    else $error("external low not seen as warning");
  AST_OT_FLAG: assert property (s_hot |-> !o_protection_flag_reg[3] && !o_conv_on)
    else $error("hot controller left running");
  AST_OC_FAST: assert property ($fell(o_protection_flag_reg[1]) |-> o_hs_force_off && !o_ls_force_on && !o_conv_on)
    else $error("overcurrent not a fast off");
  AST_UV_REGULAR: assert property ($fell(o_protection_flag_reg[2]) |-> o_regular_off && !o_conv_on)
    else $error("undervoltage not a regular off");
  AST_TR_FAST: assert property ($fell(o_protection_flag_reg[4]) |-> o_hs_force_off && !o_ls_force_on)
    else $error("ramp fault not a fast off");
  AST_OV_CLAMP: assert property ($fell(o_protection_flag_reg[5]) |-> o_hs_force_off && o_ls_force_on)
    else $error("overvoltage switches wrong");
endmodule
bind pfm_fault_manager pfm_fault_manager_asserts i_chk (.i_clock, .i_resetn, .i_vout_mv, .i_vset_mv, .i_temp_c,
  .i_steady, .i_pg_low_95, .i_power_ok_pin_in, .o_protection_flag_reg, .o_power_ok_pin_oe, .o_power_ok_pin_out,
  .o_conv_on, .o_regular_off, .o_hs_force_off, .o_ls_force_on);

// File: tb/pfm_fault_manager_tb.sv
// self-checking bench of the protection and fault manager
`timescale 1ns/1ns
`define CMP(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module pfm_fault_manager_tb;
  logic        i_clock = 0, i_resetn = 0, i_steady = 1, i_ramping_up = 0, i_turn_on = 1, i_pg_low_95 = 0;
  logic        i_cur_limit = 0, i_cur_limit_comp = 0, i_cfg_we = 0, i_st_clr = 0, peer = 0, ext = 0, look = 0;
  logic [15:0] i_vout_mv = 16'h03e8, i_vset_mv = 16'h03e8, i_vramp_mv = 16'h0, i_prebias_mv = 16'h0, e, m;
  logic [7:0]  i_temp_c = 8'h19, i_ov_pct = 8'h78, i_cfg_wdata = 8'h0, rp;
  logic [1:0]  i_cfg_sel = 2'h0;
  logic [5:0]  i_st_clr_mask = 6'h0;
  logic [15:0] expq[$], mq[$];
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  wire  [7:0]  o_cfg_rdata;
  wire  [5:0]  o_protection_flag_reg;
  wire         o_power_ok_pin_oe, o_power_ok_pin_out, o_group_oe, o_group_out, o_conv_on, o_regular_off;
  wire         o_hs_force_off, o_ls_force_on, o_pg_msg, o_temp_msg, i_power_ok_pin_in, i_group_in;
  wire  [15:0] obs = {o_cfg_rdata, 3'h0, o_ls_force_on, o_conv_on, o_group_oe, o_power_ok_pin_oe, o_pg_msg};

  pfm_fault_manager #(.HICCUP_CYC(20)) i_pfm_fault_manager (.*);
  pfm_line_peer i_pfm_line_peer (.i_group_oe(o_group_oe), .i_pg_oe(o_power_ok_pin_oe), .i_peer_fault(peer),
    .i_ext_pg_low(ext), .o_group_line(i_group_in), .o_pg_line(i_power_ok_pin_in));

  initial forever #5 i_clock = ~i_clock;

  // the watcher pairs each shown result with the oldest noted expectation
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize;
    end
    if (look)
    begin
      e = expq.pop_front();
      m = mq.pop_front();
      `CMP(obs & m, e & m)
    end
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input [1:0] s, input [7:0] d);
    @(negedge i_clock);
    {i_cfg_sel, i_cfg_wdata, i_cfg_we} = {s, d, 1'b1};
    @(negedge i_clock);
    i_cfg_we = 0;
  endtask

  task automatic chk(input [1:0] s, input [15:0] ex, input [15:0] mk);
    @(negedge i_clock);
    i_cfg_sel = s;
    @(negedge i_clock);
    expq.push_back(ex);
    mq.push_back(mk);
    look = 1;
    @(negedge i_clock);
    look = 0;
  endtask

  // conditions go first, the clear a few cycles later, so set never races clear
  task automatic nominal;
    @(negedge i_clock);
    {i_vout_mv, i_vramp_mv, i_temp_c, i_steady, i_ramping_up, i_cur_limit_comp} = {16'h03e8, 16'h0, 8'h19, 3'b100};
    {peer, ext, i_pg_low_95} = 3'b000;
    repeat (4) @(negedge i_clock);
    {i_st_clr, i_st_clr_mask} = {1'b1, 6'h3e};
    @(negedge i_clock);
    i_st_clr = 0;
    repeat (60) @(negedge i_clock);
    chk(3, 16'h3e08, 16'h3e08);
  endtask

  task automatic fault(input [7:0] pc1, current_limit_setup, input [15:0] vo, vr, input [7:0] t, input [2:0] src,
                       input [5:0] ef, input l, input [2:0] b);
    rp = $urandom;
    wr(0, rp);
    wr(1, pc1);
    wr(2, current_limit_setup);
    @(negedge i_clock);
    {i_vout_mv, i_vramp_mv, i_temp_c, i_steady, i_ramping_up, i_cur_limit_comp} = {vo, vr, t, src};
    repeat (8) @(negedge i_clock);
    chk(3, {2'h0, ef, 8'h0}, 16'h3e00);
    if (ef != 6'h3e)
      chk(3, {11'h0, l, 1'b0, rp[b], 2'h0}, 16'h001c);
    nominal;
    $display("fault case %h done", ef);
  endtask

  initial
  begin
    void'($urandom(32'h9d922b03));
    repeat (16) @(negedge i_clock);
    i_resetn = 1;
    chk(0, 16'h3f00, 16'hff00);
    chk(1, 16'h0000, 16'hff00);
    chk(2, 16'h0000, 16'hff00);
    chk(3, 16'h3f00, 16'h3f00);
    wr(3, 8'h00);
    chk(3, 16'h3f00, 16'h3f00);
    $display("reset values done");
    for (int k = 0; k < 4; k++)
    begin
      rp = $urandom;
      wr(0, rp);
      @(negedge i_clock);
      i_vout_mv = k == 1 ? 16'h044d : (k == 2 ? 16'h03b6 : 16'h044c);
      i_pg_low_95 = (k == 2);
      ext = (k == 3);
      repeat (6) @(negedge i_clock);
      chk(3, {7'h0, k[0] == 0, 6'h0, k[0] == 1, rp[6] & k[0]}, k == 3 ? 16'h0101 : 16'h0103);
    end
    nominal;
    $display("power ok window done");
    fault(0, 0, 16'h04b1, 0, 8'h19, 3'b100, 6'h1e, 1, 1);
    fault(0, 0, 16'h0320, 0, 8'h19, 3'b101, 6'h3c, 0, 3);
    // latching overcurrent: condition gone, flag not cleared, must stay off
    wr(1, 8'h08);
    @(negedge i_clock);
    {i_vout_mv, i_cur_limit_comp} = {16'h0320, 1'b1};
    repeat (4) @(negedge i_clock);
    {i_vout_mv, i_cur_limit_comp} = {16'h03e8, 1'b0};
    repeat (60) @(negedge i_clock);
    chk(3, 16'h0000, 16'h0008);
    nominal;
    $display("latching case done");
    fault(0, 1, 16'h0320, 0, 8'h19, 3'b001, 6'h3e, 0, 3);
    fault(0, 0, 16'h03e8, 0, 8'h83, 3'b100, 6'h36, 0, 4);
    fault(0, 0, 16'h03e8, 0, 8'h82, 3'b100, 6'h3e, 0, 4);
    fault(0, 0, 16'h02e4, 16'h03e8, 8'h19, 3'b010, 6'h2e, 0, 5);
    fault(8'h20, 0, 16'h02e4, 16'h03e8, 8'h19, 3'b010, 6'h3e, 0, 5);
    fault(0, 0, 16'h0383, 0, 8'h19, 3'b100, 6'h3a, 0, 2);
    @(negedge i_clock);
    peer = 1;
    repeat (8) @(negedge i_clock);
    chk(3, 16'h0000, 16'h0008);
    nominal;
    $display("group line done");
    summarize;
  end
endmodule

// File: tb/pfm_line_peer.sv
// peer converters and external circuit on the shared open-drain lines
`timescale 1ns/1ns
module pfm_line_peer (
  input  wire i_group_oe,
  input  wire i_pg_oe,
  input  wire i_peer_fault,
  input  wire i_ext_pg_low,
  output wire o_group_line,
  output wire o_pg_line
);
  // pull-ups: a released line reads high, never a stale level
  assign o_group_line = !(i_group_oe || i_peer_fault);
  assign o_pg_line    = !(i_pg_oe || i_ext_pg_low);
endmodule

// File: verilog/pfm_fault_manager.v
// protection and fault manager of a point-of-load converter
// Operation
// - power ok low outside 110 / 90-95 window
// - window armed only at steady state
// - warning: pin low, flag zero, gated message
// - back in window: release pin, flag one
// - external low on pin is a warning
// - any fault turns converter off
// - overcurrent only above prebias
// - overcurrent: flag zero, both switches off
// - overcurrent temperature compensation unless disabled
// - undervoltage at steady state: regular ramp-down
// - above 130C: overtemperature, regular ramp-down
// - non-latching overtemperature restarts below 120C
// - tracking error over 250mV: fast off
// - tracking protection disable bit
// - overvoltage: high side off, low side on
// - overvoltage threshold 110-130 percent, min 1.0V
// - group of one to 32 converters
// - propagated fault pulls group line low
// - eight-bit propagation configuration register
// - non-latching retry every 130ms
// - latching stays off until flag/command/power cycled
`timescale 1ns/1ns
`include "pfm_consts.vh"

module pfm_fault_manager #(
  parameter HICCUP_CYC = `PFM_HICCUP_CYC
) (
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire [15:0] i_vout_mv,
  input  wire [15:0] i_vset_mv,
  input  wire [15:0] i_vramp_mv,
  input  wire [15:0] i_prebias_mv,
  input  wire [7:0]  i_temp_c,
  input  wire        i_cur_limit,
  input  wire        i_cur_limit_comp,
  input  wire        i_steady,
  input  wire        i_ramping_up,
  input  wire        i_turn_on,
  input  wire        i_pg_low_95,
  input  wire [7:0]  i_ov_pct,
  input  wire        i_power_ok_pin_in,
  input  wire        i_group_in,
  input  wire        i_cfg_we,
  input  wire [1:0]  i_cfg_sel,
  input  wire [7:0]  i_cfg_wdata,
  input  wire        i_st_clr,
  input  wire [5:0]  i_st_clr_mask,
  output reg  [7:0]  o_cfg_rdata,
  output reg  [5:0]  o_protection_flag_reg,
  output reg         o_power_ok_pin_oe,
  output reg         o_power_ok_pin_out,
  output reg         o_group_oe,
  output reg         o_group_out,
  output reg         o_conv_on,
  output reg         o_regular_off,
  output reg         o_hs_force_off,
  output reg         o_ls_force_on,
  output reg         o_pg_msg,
  output reg         o_temp_msg
);

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  reg [7:0] prop_q;
  reg [7:0] pc1_q;
  reg [7:0] cls_q;

  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      prop_q <= `PFM_PROP_RESET;
      pc1_q  <= `PFM_PC1_RESET;
      cls_q  <= `PFM_CLS_RESET;
    end
    else if (i_cfg_we)
    begin
      case (i_cfg_sel)
        2'h0:    prop_q <= i_cfg_wdata;
        2'h1:    pc1_q  <= i_cfg_wdata;
        2'h2:    cls_q  <= i_cfg_wdata;
        default: prop_q <= prop_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // threshold arithmetic
  // ------------------------------------------------------------
  // scaled by 100 to avoid division; 16 x 8 products fit 24 bits
  wire [23:0] vout_x100 = {8'h00, i_vout_mv} * 24'd100;
  wire [23:0] pg_hi     = {8'h00, i_vset_mv} * {16'h0000, `PFM_PG_HIGH_PCT};
  wire [7:0]  pg_lo_pct = i_pg_low_95 ? `PFM_PG_LOW95_PCT : `PFM_PG_LOW90_PCT;
  wire [23:0] pg_lo     = {8'h00, i_vset_mv} * {16'h0000, pg_lo_pct};
  wire        out_window = (vout_x100 > pg_hi) || (vout_x100 < pg_lo);

  wire [7:0]  ov_pct = (i_ov_pct < `PFM_OV_MIN_PCT) ? `PFM_OV_MIN_PCT :
                       (i_ov_pct > `PFM_OV_MAX_PCT) ? `PFM_OV_MAX_PCT : i_ov_pct;
  wire [23:0] ov_raw   = {8'h00, i_vset_mv} * {16'h0000, ov_pct};
  wire [23:0] ov_floor = {8'h00, `PFM_OV_FLOOR_MV} * 24'd100;
  wire [23:0] ov_thr   = (ov_raw < ov_floor) ? ov_floor : ov_raw;

  // undervoltage threshold shares the low power-ok limit
  wire        below_uv     = vout_x100 < pg_lo;
  wire        above_prebias = i_vout_mv > i_prebias_mv;

  wire [15:0] trk_diff = (i_vout_mv > i_vramp_mv) ? (i_vout_mv - i_vramp_mv)
                                                  : (i_vramp_mv - i_vout_mv);

  // ------------------------------------------------------------
  // raw conditions
  // ------------------------------------------------------------
  // limit input selected by the compensation disable bit
  wire cur_lim  = cls_q[`PFM_CLS_TCOMP_DIS] ? i_cur_limit : i_cur_limit_comp;
  wire c_oc     = above_prebias && cur_lim && below_uv;
  wire c_uv     = i_steady && below_uv && !c_oc;
  wire c_ot     = i_temp_c > `PFM_OT_FAULT_C;
  wire c_tr     = i_ramping_up && !pc1_q[`PFM_PC1_TRACK_DIS] && (trk_diff > `PFM_TRACK_MV);
  wire c_ov     = above_prebias && (vout_x100 > ov_thr);
  wire c_pg     = (i_steady && out_window) || !i_power_ok_pin_in;

  wire [5:0] cond = {c_ov, c_tr, c_ot, c_uv, c_oc, c_pg};

  // ------------------------------------------------------------
  // sticky active-low fault flags, power ok flag follows live
  // ------------------------------------------------------------
  reg  [5:0] st_q;
  reg  [5:0] st_d;
  integer    k;

  always @*
  begin
    st_d = st_q;
    st_d[`PFM_ST_PG] = !c_pg;
    for (k = 1; k < 6; k = k + 1)
    begin
      if (i_st_clr && i_st_clr_mask[k])
        st_d[k] = 1'b1;
      if (cond[k])
        st_d[k] = 1'b0; // set wins over clear
    end
  end

  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      st_q <= `PFM_ST_RESET;
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------
  // turn-off and restart sequencing
  // ------------------------------------------------------------
  localparam ST_OFF  = 2'h0;
  localparam ST_ON   = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [1:0]  state_q;
  reg [23:0] cnt_q;
  reg        latch_q;
  reg        ot_trip_q;
  reg        ov_trip_q;
  reg        fast_q;
  reg        cmd_cycled_q;
  reg        group_q;

  wire any_fault = |cond[5:1];
  wire fast_fault = c_oc || c_tr || c_ov;
  wire latching = (c_ot && pc1_q[`PFM_PC1_OT_LATCH]) || (c_oc && pc1_q[`PFM_PC1_OC_LATCH]) ||
                  (c_uv && pc1_q[`PFM_PC1_UV_LATCH]) || (c_ov && pc1_q[`PFM_PC1_OV_LATCH]);
  wire group_pull = (c_tr && prop_q[`PFM_PROP_TRACK]) || (c_ot && prop_q[`PFM_PROP_OTEMP]) ||
                    (c_oc && prop_q[`PFM_PROP_OCUR]) || (c_uv && prop_q[`PFM_PROP_UVOLT]) ||
                    (c_ov && prop_q[`PFM_PROP_OVOLT]);
  wire peer_off = !i_group_in && !group_q;
  wire flags_ok = &st_q[5:1];
  wire hiccup_done = cnt_q == 24'h000000;
  wire cond_gone = !any_fault && !peer_off;
  wire ot_clear = i_temp_c < `PFM_OT_WARN_C;

  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q      <= ST_OFF;
      cnt_q        <= 24'h000000;
      latch_q      <= 1'b0;
      ot_trip_q    <= 1'b0;
      ov_trip_q    <= 1'b0;
      fast_q       <= 1'b0;
      cmd_cycled_q <= 1'b0;
      group_q      <= 1'b0;
    end
    else
    begin
      group_q <= group_pull;
      if (!i_turn_on)
        cmd_cycled_q <= 1'b1;
      case (state_q)
        ST_OFF:
        begin
          if (i_turn_on && cond_gone)
            state_q <= ST_ON;
        end
        ST_ON:
        begin
          if (!i_turn_on)
            state_q <= ST_OFF;
          else if (any_fault || peer_off)
          begin
            state_q      <= ST_WAIT;
            cnt_q        <= HICCUP_CYC[23:0];
            latch_q      <= latching;
            ot_trip_q    <= c_ot;
            ov_trip_q    <= c_ov;
            fast_q       <= fast_fault || (peer_off && !i_group_in && 1'b0);
            cmd_cycled_q <= 1'b0;
          end
        end
        ST_WAIT:
        begin
          if (!hiccup_done)
            cnt_q <= cnt_q - 24'h000001;
          if (ot_trip_q && !latch_q && ot_clear && !c_ot)
            state_q <= ST_ON;
          else if (hiccup_done && cond_gone && i_turn_on &&
                   (!latch_q || flags_ok || cmd_cycled_q))
          begin
            state_q   <= ST_ON;
            ov_trip_q <= 1'b0;
            fast_q    <= 1'b0;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_cfg_rdata           <= 8'h00;
      o_protection_flag_reg <= `PFM_ST_RESET;
      o_power_ok_pin_oe     <= 1'b1;
      o_power_ok_pin_out    <= 1'b0;
      o_group_oe            <= 1'b0;
      o_group_out           <= 1'b0;
      o_conv_on             <= 1'b0;
      o_regular_off         <= 1'b0;
      o_hs_force_off        <= 1'b1;
      o_ls_force_on         <= 1'b0;
      o_pg_msg              <= 1'b0;
      o_temp_msg            <= 1'b0;
    end
    else
    begin
      case (i_cfg_sel)
        2'h0:    o_cfg_rdata <= prop_q;
        2'h1:    o_cfg_rdata <= pc1_q;
        2'h2:    o_cfg_rdata <= cls_q;
        default: o_cfg_rdata <= {2'h0, st_q};
      endcase
      o_protection_flag_reg <= st_q;
      // internal pull only; external low is seen on the input
      o_power_ok_pin_oe     <= !i_steady || (i_steady && out_window);
      o_power_ok_pin_out    <= 1'b0;
      o_group_oe            <= group_pull;
      o_group_out           <= 1'b0;
      o_conv_on             <= (state_q == ST_ON) && !any_fault && !peer_off;
      o_regular_off         <= (state_q == ST_WAIT) && !fast_q;
      o_hs_force_off        <= (state_q != ST_ON) && fast_q || (state_q == ST_OFF);
      o_ls_force_on         <= (state_q == ST_WAIT) && ov_trip_q;
      o_pg_msg              <= c_pg && prop_q[`PFM_PROP_PG_MSG];
      o_temp_msg            <= !ot_clear && prop_q[`PFM_PROP_TEMP_MSG];
    end
  end

endmodule
